// ==== dmio_ports.sv ====
// two 8-bit multifunction i/o ports with an apb register slave
//
// Operation
// - each first-port bit is independently input or output.
// - direction bit 1 drives the pin from its data latch bit.
// - reset clears first-port latch and direction, sets input enables.
// - first-port read gives 0 where direction and input enable are 0.
// - first-port read gives pin level for enabled input bits.
// - first-port read gives latch value for output bits.
// - bit read-modify-write uses pin level for input bits.
// - first-port pins feed converter, key wakeup and external interrupt.
// - segment select 0 drives the second-port pin from its latch.
// - segment select 1 hands the pin to the lcd driver.
// - reset sets second-port latch to ones, clears segment selects.
// - second-port data reads latch; pin register reads pin levels.
// - pin readback of lcd segment bits returns zero.
// - second port offers lcd segment output bit by bit.
`include "dmio_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dmio_ports
   import dmio_pkg::*;
(
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire dmio_byte_t P6_PIN_IN,
   output dmio_byte_t P6_PIN_OUT,
   output dmio_byte_t P6_PIN_OE_N,
   output dmio_byte_t ANALOG_CHANNEL_IN,
   output dmio_byte_t KEY_WAKEUP_INPUT,
   output logic EXTERNAL_IRQ_ZERO,
   input wire dmio_byte_t P7_PIN_IN,
   output dmio_byte_t P7_PIN_OUT,
   output dmio_byte_t P7_PIN_OE_N,
   input wire dmio_byte_t LCD_SEGMENT_LINE
);

   // ****************************************************************
   // registers
   // ****************************************************************
   dmio_byte_t p6_data_q;
   dmio_byte_t p6_data_d;
   dmio_byte_t p6_dir_q;
   dmio_byte_t p6_inen_q;
   dmio_byte_t p7_data_q;
   dmio_byte_t p7_seg_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   dmio_byte_t p6_pin_sync;
   dmio_byte_t p7_pin_sync;
   dmio_byte_t p6_read;
   dmio_byte_t p6_digital;
   dmio_byte_t p6_analog;

   // ****************************************************************
   // pin synchronisers and first-port read view
   // ****************************************************************
   dmio_sync8 u_p6_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .din(P6_PIN_IN),
      .dout(p6_pin_sync)
   );

   dmio_sync8 u_p7_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .din(P7_PIN_IN),
      .dout(p7_pin_sync)
   );

   dmio_p6_view u_p6_view (
      .dir(p6_dir_q),
      .inen(p6_inen_q),
      .latch(p6_data_q),
      .pin(p6_pin_sync),
      .read_val(p6_read),
      .digital_in(p6_digital),
      .analog_sel(p6_analog)
   );

   // ****************************************************************
   // apb address decode
   // ****************************************************************
   wire logic [13:0] word_idx = PADDR[15:2];
   wire logic aligned = (PADDR[1:0] == 2'b00);
   wire logic hit_p6_data = aligned && word_idx == `DMIO_IDX_P6_DATA;
   wire logic hit_p7_data = aligned && word_idx == `DMIO_IDX_P7_DATA;
   wire logic hit_p6_dir = aligned && word_idx == `DMIO_IDX_P6_DIR;
   wire logic hit_p6_inen = aligned && word_idx == `DMIO_IDX_P6_INEN;
   wire logic hit_p7_pins = aligned && word_idx == `DMIO_IDX_P7_PINS;
   wire logic hit_p7_seg = aligned && word_idx == `DMIO_IDX_P7_SEG;
   wire logic hit_bitop = aligned && word_idx == `DMIO_IDX_P6_BITOP;
   wire logic hit_any = hit_p6_data | hit_p7_data | hit_p6_dir |
      hit_p6_inen | hit_p7_pins | hit_p7_seg | hit_bitop;
   // the pin register is read only; a write to it is an error
   wire logic bad_acc = !hit_any || (PWRITE && hit_p7_pins);
   wire logic setup = PSEL && !PENABLE;
   wire logic wr = PSEL && PENABLE && PWRITE && PSTRB[0] && !bad_acc;
   wire logic wr_p6_data = wr && hit_p6_data;
   wire logic wr_p7_data = wr && hit_p7_data;
   wire logic wr_p6_dir = wr && hit_p6_dir;
   wire logic wr_p6_inen = wr && hit_p6_inen;
   wire logic wr_p7_seg = wr && hit_p7_seg;
   wire logic wr_bitop = wr && hit_bitop;
   wire logic [2:0] bitop_idx =
      PWDATA[`DMIO_BITOP_IDX_MSB:`DMIO_BITOP_IDX_LSB];
   wire logic bitop_val = PWDATA[`DMIO_BITOP_VAL];

   // readback of lcd segment bits returns zero
   wire dmio_byte_t p7_pins_rd = p7_pin_sync & ~p7_seg_q;
   wire dmio_byte_t rd_byte =
      hit_p6_data ? p6_read :
      hit_p7_data ? p7_data_q :
      hit_p6_dir ? p6_dir_q :
      hit_p6_inen ? p6_inen_q :
      hit_p7_pins ? p7_pins_rd :
      hit_p7_seg ? p7_seg_q : 8'h00;

   // ****************************************************************
   // first-port bit operation: input bits take the pin level
   // ****************************************************************
   always_comb begin
      p6_data_d = p6_data_q;
      if (wr_p6_data) begin
         p6_data_d = PWDATA[7:0];
      end else if (wr_bitop) begin
         p6_data_d = p6_read;
         p6_data_d[bitop_idx] = bitop_val;
      end
   end

   // ****************************************************************
   // register file
   // ****************************************************************
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         p6_data_q <= `DMIO_RST_P6_DATA;
         p6_dir_q <= `DMIO_RST_P6_DIR;
         p6_inen_q <= `DMIO_RST_P6_INEN;
      end else begin
         p6_data_q <= p6_data_d;
         if (wr_p6_dir) begin
            p6_dir_q <= PWDATA[7:0];
         end
         if (wr_p6_inen) begin
            p6_inen_q <= PWDATA[7:0];
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         p7_data_q <= `DMIO_RST_P7_DATA;
         p7_seg_q <= `DMIO_RST_P7_SEG;
      end else begin
         if (wr_p7_data) begin
            p7_data_q <= PWDATA[7:0];
         end
         if (wr_p7_seg) begin
            p7_seg_q <= PWDATA[7:0];
         end
      end
   end

   // read data and error are caught in the setup cycle
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= {24'h00_0000, PWRITE ? 8'h00 : rd_byte};
         pslverr_q <= bad_acc;
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && pslverr_q;

   // ****************************************************************
   // pin drive and alternate functions
   // ****************************************************************
   assign P6_PIN_OUT = p6_data_q;
   assign P6_PIN_OE_N = ~p6_dir_q;
   assign ANALOG_CHANNEL_IN = p6_analog;
   assign KEY_WAKEUP_INPUT = p6_digital;
   assign EXTERNAL_IRQ_ZERO = p6_digital[`DMIO_IRQ_BIT];
   // gpio bits sink only, so a latch of 1 leaves the pin free as input
   assign P7_PIN_OUT = p7_seg_q & LCD_SEGMENT_LINE;
   assign P7_PIN_OE_N = ~p7_seg_q & p7_data_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   sequence s_rd_setup(logic hit);
      PSEL && !PENABLE && !PWRITE && hit;
   endsequence

   a_p6_reset_vals: assert property (
      @(posedge CORE_CLK) $fell(RST) |->
         (p6_data_q == 8'h00 && p6_dir_q == 8'h00 && p6_inen_q == 8'hff))
      else $error("first port reset values wrong");

   a_p7_reset_vals: assert property (
      @(posedge CORE_CLK) $fell(RST) |->
         (p7_data_q == 8'hff && p7_seg_q == 8'h00 && P7_PIN_OE_N == 8'hff))
      else $error("second port reset values wrong");

   a_p6_dir_write: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      wr_p6_dir |=> (P6_PIN_OE_N == ~$past(PWDATA[7:0])))
      else $error("direction write did not steer pin enable");

   a_p6_read_zero: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      s_rd_setup(hit_p6_data) |=>
         ((PRDATA[7:0] & ~$past(p6_dir_q) & ~$past(p6_inen_q)) == 8'h00))
      else $error("analog bit read not zero");

   a_p6_read_pin: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      s_rd_setup(hit_p6_data) |=>
         ((PRDATA[7:0] & ~$past(p6_dir_q) & $past(p6_inen_q)) ==
          ($past(p6_pin_sync) & ~$past(p6_dir_q) & $past(p6_inen_q))))
      else $error("input bit read not pin level");

   a_p6_read_latch: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      s_rd_setup(hit_p6_data) |=>
         ((PRDATA[7:0] & $past(p6_dir_q)) ==
          ($past(p6_data_q) & $past(p6_dir_q))))
      else $error("output bit read not latch");

   a_p6_bit_rmw: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      wr_bitop |=> (p6_data_q[$past(bitop_idx)] == $past(bitop_val) &&
         ((p6_data_q ^ $past(p6_read)) &
          ~(8'h01 << $past(bitop_idx))) == 8'h00))
      else $error("bit operation result wrong");

   a_p7_gpio_drive: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (wr_p7_seg && PWDATA[0] == 1'b0) ##1 !wr_p7_data |=>
         (P7_PIN_OE_N[0] == $past(p7_data_q[0])))
      else $error("gpio bit not driven from latch");

   a_p7_lcd_drive: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (wr_p7_seg && PWDATA[0]) |=>
         (!P7_PIN_OE_N[0] && P7_PIN_OUT[0] == LCD_SEGMENT_LINE[0]))
      else $error("segment bit not handed to lcd driver");

   a_p7_pins_read: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      s_rd_setup(hit_p7_pins) |=>
         (PRDATA[7:0] == ($past(p7_pin_sync) & ~$past(p7_seg_q))))
      else $error("pin register read wrong");

   a_apb_unmapped: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (setup && !hit_any) ##1 (PSEL && PENABLE) |-> PSLVERR)
      else $error("unmapped access not flagged");

   a_p6_analog_view: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      ANALOG_CHANNEL_IN == (~p6_dir_q & ~p6_inen_q))
      else $error("analog select does not follow mode");

   a_p6_wake_gate: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (KEY_WAKEUP_INPUT & (p6_dir_q | ~p6_inen_q)) == 8'h00)
      else $error("wakeup input seen from non-input bit");

   a_p6_inen_write: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      wr_p6_inen |=> (p6_inen_q == $past(PWDATA[7:0])))
      else $error("input enable write lost");

   a_p7_seg_write: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      wr_p7_seg |=> (p7_seg_q == $past(PWDATA[7:0])))
      else $error("segment select write lost");

   a_bad_write_keep: assert property (
      @(posedge CORE_CLK) disable iff (RST)
      (PSEL && PENABLE && PWRITE && bad_acc) |=>
         ($stable(p6_data_q) && $stable(p6_dir_q) && $stable(p6_inen_q) &&
          $stable(p7_data_q) && $stable(p7_seg_q)))
      else $error("refused write changed a register");

endmodule // dmio_ports
`default_nettype wire

// ==== dmio_cfg.svh ====
// constants for the dual multifunction i/o ports: offsets, resets, fields
`ifndef DMIO_CFG_SVH
`define DMIO_CFG_SVH

// ****************************************************************
// register word indices (byte address is four times the index)
// ****************************************************************
`define DMIO_IDX_P6_DATA 14'h0006
`define DMIO_IDX_P7_DATA 14'h0007
`define DMIO_IDX_P6_DIR 14'h0014
`define DMIO_IDX_P6_INEN 14'h0015
`define DMIO_IDX_P7_PINS 14'h0024
`define DMIO_IDX_P7_SEG 14'h0faf
`define DMIO_IDX_P6_BITOP 14'h0030

// ****************************************************************
// reset values
// ****************************************************************
`define DMIO_RST_P6_DATA 8'h00
`define DMIO_RST_P6_DIR 8'h00
`define DMIO_RST_P6_INEN 8'hff
`define DMIO_RST_P7_DATA 8'hff
`define DMIO_RST_P7_SEG 8'h00

// ****************************************************************
// fields
// ****************************************************************
`define DMIO_BITOP_IDX_LSB 0
`define DMIO_BITOP_IDX_MSB 2
`define DMIO_BITOP_VAL 3
`define DMIO_IRQ_BIT 3
`define DMIO_PORT_W 8

`endif

// ==== dmio_pkg.sv ====
// types shared by the dual multifunction i/o port files
`default_nettype none
package dmio_pkg;
   typedef logic [7:0] dmio_byte_t;
   // pin function of one bit of the first port, gray along the path
   typedef enum logic [1:0] {
      DMIO_ANALOG = 2'b00,
      DMIO_INPUT = 2'b01,
      DMIO_OUTPUT = 2'b11
   } dmio_p6_mode_t;
endpackage
`default_nettype wire

// ==== dmio_sync8.sv ====
// two-flop synchroniser for an 8-bit group of pin inputs
`include "dmio_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dmio_sync8
   import dmio_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire dmio_byte_t din,
   output dmio_byte_t dout
);
   dmio_byte_t meta_q;
   dmio_byte_t sync_q;

   genvar g;
   generate
      for (g = 0; g < `DMIO_PORT_W; g = g + 1) begin : g_bit
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_q[g] <= 1'b0;
               sync_q[g] <= 1'b0;
            end else begin
               meta_q[g] <= din[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   assign dout = sync_q;
endmodule // dmio_sync8
`default_nettype wire

// ==== dmio_p6_view.sv ====
// per-bit mode decode and read value of the first port
`include "dmio_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dmio_p6_view
   import dmio_pkg::*;
(
   input wire dmio_byte_t dir,
   input wire dmio_byte_t inen,
   input wire dmio_byte_t latch,
   input wire dmio_byte_t pin,
   output dmio_byte_t read_val,
   output dmio_byte_t digital_in,
   output dmio_byte_t analog_sel
);
   genvar g;
   generate
      for (g = 0; g < `DMIO_PORT_W; g = g + 1) begin : g_bit
         dmio_p6_mode_t mode;
         always_comb begin
            if (dir[g]) begin
               mode = DMIO_OUTPUT;
            end else if (inen[g]) begin
               mode = DMIO_INPUT;
            end else begin
               mode = DMIO_ANALOG;
            end
         end
         always_comb begin
            case (mode)
               DMIO_OUTPUT: read_val[g] = latch[g];
               DMIO_INPUT: read_val[g] = pin[g];
               default: read_val[g] = 1'b0;
            endcase
         end
         assign digital_in[g] = (mode == DMIO_INPUT) ? pin[g] : 1'b0;
         assign analog_sel[g] = (mode == DMIO_ANALOG);
      end
   endgenerate
endmodule // dmio_p6_view
`default_nettype wire

// ==== dmio_board.sv ====
// board model: pin wiring, outside drivers and an lcd segment source
`timescale 1ns/100ps
`default_nettype none
module dmio_board
   import dmio_pkg::*;
(
   input wire logic clk,
   input wire dmio_byte_t ext6,
   input wire dmio_byte_t ext7,
   input wire dmio_byte_t p6_out,
   input wire dmio_byte_t p6_oe_n,
   input wire dmio_byte_t p7_out,
   input wire dmio_byte_t p7_oe_n,
   output dmio_byte_t p6_pin,
   output dmio_byte_t p7_pin,
   output dmio_byte_t seg_line
);
   // the chip wins where it drives, else the outside source
   assign p6_pin = (~p6_oe_n & p6_out) | (p6_oe_n & ext6);
   // released bits follow ext7, which stands for pull-up or sender
   assign p7_pin = (~p7_oe_n & p7_out) | (p7_oe_n & ext7);
   // segment waveform changes every cycle
   initial seg_line = 8'h5a;
   always @(posedge clk) seg_line <= seg_line + 8'h3b;
endmodule // dmio_board
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the dual multifunction i/o ports
`include "dmio_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench
   import dmio_pkg::*;
();
   logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   dmio_byte_t ext6, ext7, p6_in, p6_out, p6_oe_n, ana, wake;
   dmio_byte_t p7_in, p7_out, p7_oe_n, seg;
   int n_errors, n_compared, m_dir, m_inen, m_lat6, m_lat7, m_seg, v;

   dmio_ports DUT (.CORE_CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .P6_PIN_IN(p6_in), .P6_PIN_OUT(p6_out), .P6_PIN_OE_N(p6_oe_n),
      .ANALOG_CHANNEL_IN(ana), .KEY_WAKEUP_INPUT(wake),
      .EXTERNAL_IRQ_ZERO(irq), .P7_PIN_IN(p7_in), .P7_PIN_OUT(p7_out),
      .P7_PIN_OE_N(p7_oe_n), .LCD_SEGMENT_LINE(seg));
   dmio_board board (.clk(clk), .ext6(ext6), .ext7(ext7),
      .p6_out(p6_out), .p6_oe_n(p6_oe_n), .p7_out(p7_out),
      .p7_oe_n(p7_oe_n), .p6_pin(p6_in), .p7_pin(p7_in), .seg_line(seg));

   // ****************************************************************
   // checks and bus cycles
   // ****************************************************************
   task automatic test_done();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_bus(input logic [32:0] got, input logic [32:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input dmio_byte_t got, input dmio_byte_t exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [13:0] idx, input int wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= 32'(wd);
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         test_done();
      end
   endtask

   task automatic rdchk(input logic [13:0] idx, input int exp);
      apb(1'b0, idx, 0);
      chk_bus({err, rd}, {1'b0, 32'(exp & 255)});
   endtask

   task automatic pins_chk();
      @(negedge clk);
      chk_pin(p6_out, 8'(m_lat6));
      chk_pin(p6_oe_n, 8'(~m_dir));
      chk_pin(ana, 8'(~m_dir & ~m_inen));
      chk_pin(wake, 8'(~m_dir & m_inen & ext6));
      chk_pin(8'(irq),
         8'(m_inen & ~m_dir & ext6) >> `DMIO_IRQ_BIT & 8'h01);
      chk_pin(p7_oe_n, 8'(~m_seg & m_lat7));
      chk_pin(p7_out, 8'(m_seg) & seg);
   endtask

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 51'h0};
      {ext6, ext7, n_errors, n_compared} = {8'h00, 8'hff, 64'h0};
      m_dir = 0;
      m_inen = 255;
      m_lat6 = 0;
      m_lat7 = 255;
      m_seg = 0;
      void'($urandom(4));
      for (int r = 0; r < 2; r++) begin
         repeat (8) @(posedge clk);
         rst <= 1'b0;
         rdchk(`DMIO_IDX_P6_INEN, 255);
         rdchk(`DMIO_IDX_P7_DATA, 255);
         rdchk(`DMIO_IDX_P7_SEG, 0);
         rdchk(`DMIO_IDX_P6_DATA, int'(ext6));
         pins_chk();
         apb(1'b1, `DMIO_IDX_P6_DIR, 255);
         m_dir = 255;
         rdchk(`DMIO_IDX_P6_DATA, 0);
         for (int i = 0; i < 12 && r == 0; i++) begin
            @(posedge clk);
            ext6 <= 8'($urandom);
            ext7 <= 8'($urandom);
            m_inen = $urandom_range(255);
            m_dir = $urandom_range(255) & m_inen;
            m_lat6 = $urandom_range(255);
            m_lat7 = $urandom_range(255);
            m_seg = $urandom_range(255);
            apb(1'b1, `DMIO_IDX_P6_DIR, 0);
            apb(1'b1, `DMIO_IDX_P6_INEN, m_inen);
            apb(1'b1, `DMIO_IDX_P6_DATA, m_lat6);
            apb(1'b1, `DMIO_IDX_P6_DIR, m_dir);
            apb(1'b1, `DMIO_IDX_P7_DATA, m_lat7);
            apb(1'b1, `DMIO_IDX_P7_SEG, m_seg);
            pins_chk();
            v = (m_dir & m_lat6) | (~m_dir & m_inen & ext6);
            rdchk(`DMIO_IDX_P6_DATA, v);
            rdchk(`DMIO_IDX_P7_DATA, m_lat7);
            apb(1'b0, `DMIO_IDX_P7_PINS, 0);
            v = ~m_seg & m_lat7 & ext7;
            chk_bus({err, rd & ~32'(m_seg)}, {1'b0, 32'(v & 255)});
         end
         for (int b = 0; b < 8 && r == 0; b++) begin
            v = $urandom_range(1);
            apb(1'b1, `DMIO_IDX_P6_BITOP, b | (v << 3));
            m_lat6 = (m_dir & m_lat6) | (~m_dir & m_inen & ext6);
            m_lat6 = (m_lat6 & ~(1 << b)) | (v << b);
            pins_chk();
         end
         apb(1'b0, 14'h0100, 0);
         chk_bus({err, rd}, {1'b1, 32'h0});
         apb(1'b1, `DMIO_IDX_P7_PINS, 0);
         chk_bus({err, rd}, {1'b1, 32'h0});
         @(posedge clk);
         rst <= 1'b1;
         m_dir = 0;
         m_inen = 255;
         m_lat6 = 0;
         m_lat7 = 255;
         m_seg = 0;
      end
      test_done();
   end
endmodule // testbench
`default_nettype wire
